// file: src/bavg_buf.v
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer with registered flags
module bavg_buf #(
  parameter WIDTH = 64
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Fill side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Empty flag, used to pace the source
  output reg empty
);

  reg [WIDTH-1:0] entry0; // Storage slot 0
  reg [WIDTH-1:0] entry1; // Storage slot 1
  reg wr_ptr; // Next slot to fill
  reg rd_ptr; // Next slot to drain
  reg [1:0] count; // Words held
  wire push;
  wire pop;
  reg [1:0] next_count;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = rd_ptr ? entry1 : entry0;

  // Occupancy after this cycle
  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 2'h1;
    end else if (pop & ~push) begin
      next_count = count - 2'h1;
    end
  end

  // Pointers, storage and flags
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      entry0 <= {WIDTH{1'b0}};
      entry1 <= {WIDTH{1'b0}};
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      empty <= 1'b1;
    end else begin
      if (push) begin
        if (wr_ptr) begin
          entry1 <= in_data;
        end else begin
          entry0 <= in_data;
        end
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= next_count;
      in_ready <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
      empty <= (next_count == 2'h0);
    end
  end

endmodule
`default_nettype wire

// file: src/bavg_mem.v
`timescale 1ns/100ps
`default_nettype none
`include "bavg_regs.vh"

// Per-position sum store, both channels side by side in one word
module bavg_mem (
  // Clock
  input wire clock,
  // Write side
  input wire wr_en,
  input wire [`BAVG_POS_W-1:0] wr_addr,
  input wire [2*`BAVG_SUM_W-1:0] wr_data,
  // Read side
  input wire rd_en,
  input wire [`BAVG_POS_W-1:0] rd_addr,
  output reg [2*`BAVG_SUM_W-1:0] rd_data
);

  // Storage, not reset: every word within the segment size is rewritten in the first segment
  reg [2*`BAVG_SUM_W-1:0] store [0:`BAVG_DEPTH-1];

  // One write port, registered read port
  always @(posedge clock) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: src/bavg_regs.vh
`ifndef BAVG_REGS_VH
`define BAVG_REGS_VH

// Register offsets on the register port
`define BAVG_OFS_MODE_CH0 16'ha5be
`define BAVG_OFS_MODE_CH1 16'ha5bf
`define BAVG_OFS_THR_CH0 16'ha5c8
`define BAVG_OFS_THR_CH1 16'ha5c9
`define BAVG_OFS_REPL_CH0 16'ha5d2
`define BAVG_OFS_REPL_CH1 16'ha5d3
`define BAVG_OFS_AVG_COUNT 16'ha5e0
`define BAVG_OFS_SEG_SIZE 16'ha5e1
`define BAVG_OFS_CH_ENABLE 16'ha5e2
`define BAVG_OFS_STATUS 16'ha5e3

// Averaging mode codes
`define BAVG_MODE_UNCOND 2'h0
`define BAVG_MODE_KEEP_ABOVE 2'h1
`define BAVG_MODE_KEEP_BELOW 2'h2

// Level range in ADC LSB
`define BAVG_LEVEL_MAX 32'sh000007ff
`define BAVG_LEVEL_MIN 32'shfffff801
// Same bounds at the stored level width
`define BAVG_LEVEL_MAX16 16'h07ff
`define BAVG_LEVEL_MIN16 16'hf801

// Channel enable codes
`define BAVG_CH_ONLY0 2'h1
`define BAVG_CH_ONLY1 2'h2
`define BAVG_CH_BOTH 2'h3

// Reset values
`define BAVG_RST_MODE 2'h0
`define BAVG_RST_LEVEL 16'h0000
`define BAVG_RST_AVG_COUNT 11'h002
`define BAVG_RST_SEG_SIZE 11'h400
`define BAVG_RST_CH_ENABLE 2'h1

// Count limits
`define BAVG_MIN_COUNT 11'h002
`define BAVG_MAX_COUNT 11'h400

// Field widths
`define BAVG_POS_W 10
`define BAVG_CNT_W 11
`define BAVG_RAW_W 16
`define BAVG_SUM_W 32
`define BAVG_DEPTH 1024

`endif

// file: src/bavg_top.v
`timescale 1ns/100ps
`default_nettype none
`include "bavg_regs.vh"

// Block averager with level-gated sample selection, two channels
module bavg_top (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  // Raw sample stream
  input wire [`BAVG_RAW_W-1:0] sample_ch0,
  input wire [`BAVG_RAW_W-1:0] sample_ch1,
  input wire sample_valid,
  output wire sample_ready,
  // Averaged output stream
  output reg [`BAVG_SUM_W-1:0] sum_data,
  output reg sum_channel,
  output reg sum_valid,
  input wire sum_ready
);

  // Configuration, both channels packed
  reg [3:0] mode_all; // Averaging mode, 2 bits per channel
  reg [31:0] thr_all; // Threshold level, 16 bits per channel
  reg [31:0] repl_all; // Replacement value, 16 bits per channel
  reg [`BAVG_CNT_W-1:0] average_count; // Segments summed
  reg [`BAVG_CNT_W-1:0] segment_size; // Samples per segment
  reg [1:0] ch_enable; // Active channels
  reg restart; // Pulse after any config write

  // Accumulation position
  reg [`BAVG_POS_W-1:0] pos; // Sample index in segment
  reg [`BAVG_CNT_W-1:0] seg_idx; // Segment index in block

  // Pipeline stage between memory read and write-back
  reg a_valid;
  reg a_first; // First segment: ignore stored sum
  reg a_last; // Last segment: hand sums out
  reg [`BAVG_POS_W-1:0] a_pos;
  reg [31:0] a_sel; // Selected samples

  // Datapath wires
  wire [31:0] raw_all;
  wire [31:0] sel_all;
  wire [2*`BAVG_SUM_W-1:0] sum_all;
  wire [2*`BAVG_SUM_W-1:0] mem_rdata;
  wire take;
  wire seg_end;
  wire block_end;

  // Buffer wires
  wire buf_in_ready;
  wire buf_out_valid;
  wire [2*`BAVG_SUM_W-1:0] buf_out_data;
  wire buf_out_ready;
  wire buf_empty;

  // Serializer wires and state
  reg phase; // Second word of a pair pending
  wire adv;
  wire emit_hi;
  wire last_part;

  // Clamp a written level into the legal range
  function [15:0] bavg_clamp;
    input [31:0] v;
    begin
      if ($signed(v) > `BAVG_LEVEL_MAX) begin
        bavg_clamp = `BAVG_LEVEL_MAX16;
      end else if ($signed(v) < `BAVG_LEVEL_MIN) begin
        bavg_clamp = `BAVG_LEVEL_MIN16;
      end else begin
        bavg_clamp = v[15:0];
      end
    end
  endfunction

  // Register writes; any write restarts the block
  // so that a half-summed block never mixes settings
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_all <= {2{`BAVG_RST_MODE}};
      thr_all <= {2{`BAVG_RST_LEVEL}};
      repl_all <= {2{`BAVG_RST_LEVEL}};
      average_count <= `BAVG_RST_AVG_COUNT;
      segment_size <= `BAVG_RST_SEG_SIZE;
      ch_enable <= `BAVG_RST_CH_ENABLE;
      restart <= 1'b0;
    end else begin
      restart <= reg_wr;
      if (reg_wr) begin
        case (reg_addr)
          // Mode per channel
          `BAVG_OFS_MODE_CH0: begin
            mode_all[1:0] <= reg_wdata[1:0];
          end
          `BAVG_OFS_MODE_CH1: begin
            mode_all[3:2] <= reg_wdata[1:0];
          end
          // Threshold per channel, clamped
          `BAVG_OFS_THR_CH0: begin
            thr_all[15:0] <= bavg_clamp(reg_wdata);
          end
          `BAVG_OFS_THR_CH1: begin
            thr_all[31:16] <= bavg_clamp(reg_wdata);
          end
          // Replacement per channel, clamped
          `BAVG_OFS_REPL_CH0: begin
            repl_all[15:0] <= bavg_clamp(reg_wdata);
          end
          `BAVG_OFS_REPL_CH1: begin
            repl_all[31:16] <= bavg_clamp(reg_wdata);
          end
          // Counts held inside their legal span
          `BAVG_OFS_AVG_COUNT: begin
            if (reg_wdata < {21'h0, `BAVG_MIN_COUNT}) begin
              average_count <= `BAVG_MIN_COUNT;
            end else if (reg_wdata > {21'h0, `BAVG_MAX_COUNT}) begin
              average_count <= `BAVG_MAX_COUNT;
            end else begin
              average_count <= reg_wdata[`BAVG_CNT_W-1:0];
            end
          end
          `BAVG_OFS_SEG_SIZE: begin
            if (reg_wdata < {21'h0, `BAVG_MIN_COUNT}) begin
              segment_size <= `BAVG_MIN_COUNT;
            end else if (reg_wdata > {21'h0, `BAVG_MAX_COUNT}) begin
              segment_size <= `BAVG_MAX_COUNT;
            end else begin
              segment_size <= reg_wdata[`BAVG_CNT_W-1:0];
            end
          end
          // No channel at all falls back to channel 0
          `BAVG_OFS_CH_ENABLE: begin
            if (reg_wdata[1:0] == 2'h0) begin
              ch_enable <= `BAVG_CH_ONLY0;
            end else begin
              ch_enable <= reg_wdata[1:0];
            end
          end
          default: begin
            ch_enable <= ch_enable;
          end
        endcase
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `BAVG_OFS_MODE_CH0: reg_rdata <= {30'h0, mode_all[1:0]};
          `BAVG_OFS_MODE_CH1: reg_rdata <= {30'h0, mode_all[3:2]};
          `BAVG_OFS_THR_CH0: reg_rdata <= {{16{thr_all[15]}}, thr_all[15:0]};
          `BAVG_OFS_THR_CH1: reg_rdata <= {{16{thr_all[31]}}, thr_all[31:16]};
          `BAVG_OFS_REPL_CH0: reg_rdata <= {{16{repl_all[15]}}, repl_all[15:0]};
          `BAVG_OFS_REPL_CH1: reg_rdata <= {{16{repl_all[31]}}, repl_all[31:16]};
          `BAVG_OFS_AVG_COUNT: reg_rdata <= {21'h0, average_count};
          `BAVG_OFS_SEG_SIZE: reg_rdata <= {21'h0, segment_size};
          `BAVG_OFS_CH_ENABLE: reg_rdata <= {30'h0, ch_enable};
          // Live position: segment index low, sample index high
          `BAVG_OFS_STATUS: reg_rdata <= {6'h0, pos, 5'h0, seg_idx};
          // Unmapped offsets read as zero
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // Level selection and summing, one copy per channel
  assign raw_all = {sample_ch1, sample_ch0};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire signed [15:0] raw;
      wire signed [15:0] thr;
      wire signed [15:0] repl;
      wire [1:0] md;
      wire [31:0] stored;
      wire [31:0] addend;
      assign raw = raw_all[ch*16 +: 16];
      assign thr = thr_all[ch*16 +: 16];
      assign repl = repl_all[ch*16 +: 16];
      assign md = mode_all[ch*2 +: 2];
      // Equal to the threshold counts as rejected in both modes
      assign sel_all[ch*16 +: 16] =
        (md == `BAVG_MODE_KEEP_ABOVE) ? ((raw > thr) ? raw : repl) :
        (md == `BAVG_MODE_KEEP_BELOW) ? ((raw < thr) ? raw : repl) :
        raw;
      // First segment starts from zero instead of the old sum
      assign stored = a_first ? 32'h0 : mem_rdata[ch*32 +: 32];
      // Sign extend to the full sum width; no division ever
      assign addend = {{16{a_sel[ch*16+15]}}, a_sel[ch*16 +: 16]};
      assign sum_all[ch*32 +: 32] = stored + addend;
    end
  endgenerate

  // A sample is taken only while the buffer is empty; with one stage
  // in flight that bounds the buffer at two words, so none is lost
  assign take = sample_valid & buf_empty & buf_in_ready & ~restart;
  assign sample_ready = buf_empty;
  assign seg_end = ({1'b0, pos} == segment_size - `BAVG_CNT_W'h1);
  assign block_end = (seg_idx == average_count - `BAVG_CNT_W'h1);

  // Position counters over the block
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pos <= {`BAVG_POS_W{1'b0}};
      seg_idx <= {`BAVG_CNT_W{1'b0}};
    end else if (restart) begin
      pos <= {`BAVG_POS_W{1'b0}};
      seg_idx <= {`BAVG_CNT_W{1'b0}};
    end else if (take) begin
      if (seg_end) begin
        pos <= {`BAVG_POS_W{1'b0}};
        // Wrap to a fresh block after the last segment
        if (block_end) begin
          seg_idx <= {`BAVG_CNT_W{1'b0}};
        end else begin
          seg_idx <= seg_idx + `BAVG_CNT_W'h1;
        end
      end else begin
        pos <= pos + `BAVG_POS_W'h1;
      end
    end
  end

  // Stage register, aligned with the memory read data
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      a_valid <= 1'b0;
      a_first <= 1'b0;
      a_last <= 1'b0;
      a_pos <= {`BAVG_POS_W{1'b0}};
      a_sel <= 32'h0;
    end else begin
      a_valid <= take;
      if (take) begin
        a_first <= (seg_idx == {`BAVG_CNT_W{1'b0}});
        a_last <= block_end;
        a_pos <= pos;
        a_sel <= sel_all;
      end
    end
  end

  // Running sums per position
  bavg_mem u_mem (
    .clock(clock),
    .wr_en(a_valid),
    .wr_addr(a_pos),
    .wr_data(sum_all),
    .rd_en(take),
    .rd_addr(pos),
    .rd_data(mem_rdata)
  );

  // Finished sums wait here for the output side
  bavg_buf #(
    .WIDTH(2*`BAVG_SUM_W)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(a_valid & a_last),
    .in_ready(buf_in_ready),
    .in_data(sum_all),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data),
    .empty(buf_empty)
  );

  // Output serializer: ch0 word, then ch1 word when both run
  assign adv = ~sum_valid | sum_ready;
  assign emit_hi = (ch_enable == `BAVG_CH_ONLY1) |
                   ((ch_enable == `BAVG_CH_BOTH) & phase);
  assign last_part = (ch_enable != `BAVG_CH_BOTH) | phase;
  assign buf_out_ready = adv & buf_out_valid & last_part;

  // Output word register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sum_data <= 32'h0;
      sum_channel <= 1'b0;
      sum_valid <= 1'b0;
      phase <= 1'b0;
    end else if (adv) begin
      sum_valid <= buf_out_valid;
      if (buf_out_valid) begin
        // Pick the word for this phase of the pair
        if (emit_hi) begin
          sum_data <= buf_out_data[63:32];
        end else begin
          sum_data <= buf_out_data[31:0];
        end
        sum_channel <= emit_hi;
        phase <= ~last_part;
      end
    end
  end

endmodule
`default_nettype wire

// file: verif/bavg_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "bavg_regs.vh"

// Raw sample source: offers a pair and holds it until the averager takes it
module bavg_adc_model (
  // Clock
  input wire logic clock,
  // Stream to the averager
  output logic [`BAVG_RAW_W-1:0] sample_ch0,
  output logic [`BAVG_RAW_W-1:0] sample_ch1,
  output logic sample_valid,
  input wire logic sample_ready
);
  // Idle pattern that cannot pass for data
  initial begin
    sample_valid = 1'b0;
    sample_ch0 = 16'h5a5a;
    sample_ch1 = 16'ha5a5;
  end

  // Called after a falling edge; ready is judged there, where it has settled
  task send(input [`BAVG_RAW_W-1:0] c0, input [`BAVG_RAW_W-1:0] c1);
    begin
      sample_valid = 1'b1;
      sample_ch0 = c0;
      sample_ch1 = c1;
      while (sample_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
    end
  endtask

  // Released lines show the inverse of the last pair, not stale data
  task idle;
    begin
      sample_valid = 1'b0;
      sample_ch0 = ~sample_ch0;
      sample_ch1 = ~sample_ch1;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/bavg_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "bavg_regs.vh"

// Watches the register port and the output handshake of the averager
module bavg_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Averaged output stream
  input wire logic [`BAVG_SUM_W-1:0] sum_data,
  input wire logic sum_channel,
  input wire logic sum_valid,
  input wire logic sum_ready
);
  // Address classes
  wire is_thr = (reg_addr == `BAVG_OFS_THR_CH0) || (reg_addr == `BAVG_OFS_THR_CH1);
  wire is_repl = (reg_addr == `BAVG_OFS_REPL_CH0) || (reg_addr == `BAVG_OFS_REPL_CH1);
  wire is_mode = (reg_addr == `BAVG_OFS_MODE_CH0) || (reg_addr == `BAVG_OFS_MODE_CH1);
  // The four control words sit in one aligned group of four
  wire is_map = is_thr || is_repl || is_mode || (reg_addr[15:2] == 14'h2978);
  // Written level inside the range, so no clamping is expected
  wire lvl_ok = ($signed(reg_wdata) <= 2047) && ($signed(reg_wdata) >= -2047);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Steps of a write followed at once by a read of the same place
  sequence s_lvl_wr;
    reg_wr && (is_thr || is_repl) && lvl_ok;
  endsequence
  sequence s_mode_wr;
    reg_wr && is_mode && (reg_wdata < 32'h4);
  endsequence
  sequence s_same_rd;
    reg_rd && (reg_addr == $past(reg_addr));
  endsequence

  property p_rvalid_exact;
    reg_rvalid == $past(reg_rd);
  endproperty
  property p_level_readback;
    s_lvl_wr ##1 s_same_rd |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_mode_readback;
    s_mode_wr ##1 s_same_rd |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_thr_range;
    reg_rd && is_thr |=> $signed(reg_rdata) <= 2047 && $signed(reg_rdata) >= -2047;
  endproperty
  property p_repl_range;
    reg_rd && is_repl |=> $signed(reg_rdata) <= 2047 && $signed(reg_rdata) >= -2047;
  endproperty
  property p_mode_range;
    reg_rd && is_mode |=> reg_rdata[31:2] == 30'h0;
  endproperty
  property p_unmapped_zero;
    reg_rd && !is_map |=> reg_rdata == 32'h0;
  endproperty
  property p_sum_hold;
    sum_valid && !sum_ready |=> sum_valid && $stable(sum_data) && $stable(sum_channel);
  endproperty

  a_rvalid_exact: assert property (p_rvalid_exact) else $error("read answer timing wrong");
  a_level_readback: assert property (p_level_readback) else $error("level readback wrong");
  a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");
  a_repl_range: assert property (p_repl_range) else $error("replacement out of range");
  a_mode_range: assert property (p_mode_range) else $error("mode has stray bits");
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  a_sum_hold: assert property (p_sum_hold) else $error("stalled word changed");
endmodule

bind bavg_top bavg_checker u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .sum_data(sum_data), .sum_channel(sum_channel),
  .sum_valid(sum_valid), .sum_ready(sum_ready));
`default_nettype wire

// file: verif/block_average_threshold_accumulator_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "bavg_regs.vh"

module block_average_threshold_accumulator_tb;
  // Design ports
  logic clock, rst, reg_wr, reg_rd, reg_rvalid, sum_ready, sum_channel, sum_valid;
  logic sample_valid, sample_ready;
  logic [15:0] reg_addr, sample_ch0, sample_ch1;
  logic [31:0] reg_wdata, reg_rdata, sum_data, v;
  // Bookkeeping
  integer err_total = 0;
  integer samples_checked = 0;
  integer k;
  logic [32:0] got [$];
  logic [32:0] exp_q [$];
  // Case table: modes, channel enable, written average count
  // Gated modes only where the replacement sits on the rejected side
  integer m0_t [0:2] = '{1, 1, 0};
  integer m1_t [0:2] = '{2, 0, 2};
  integer en_t [0:2] = '{3, 2, 1};
  integer avg_t [0:2] = '{2, 3, 1};

  bavg_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_ch0(sample_ch0), .sample_ch1(sample_ch1),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sum_data(sum_data),
    .sum_channel(sum_channel), .sum_valid(sum_valid), .sum_ready(sum_ready));
  bavg_adc_model u_adc (.clock(clock), .sample_ch0(sample_ch0), .sample_ch1(sample_ch1),
    .sample_valid(sample_valid), .sample_ready(sample_ready));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Capture each taken word with its channel
  always @(posedge clock) begin
    if (sum_valid === 1'b1 && sum_ready === 1'b1) begin
      got.push_back({sum_channel, sum_data});
    end
  end

  task check(input [32:0] seen, input [32:0] expv);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== expv) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
    end
  endtask

  task results;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // Register tasks, entered just after a falling edge
  task reg_write(input [15:0] a, input [31:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
    end
  endtask
  task reg_read(input [15:0] a, output [31:0] d);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      // The answer stands for this one cycle only
      check(reg_rvalid, 1'b1);
      d = reg_rdata;
      @(negedge clock);
    end
  endtask
  task wr_rd(input [15:0] a, input [31:0] d, input [31:0] expv);
    begin
      reg_write(a, d);
      reg_read(a, v);
      check(v, expv);
    end
  endtask

  // Raw test pattern: pos 0 low, pos 1 on the level, pos 2 mixed
  function integer raw(input integer seg, input integer pos);
    raw = (pos == 0) ? seg - 40 : ((pos == 1) ? 10 : 1500 * seg - 1000);
  endfunction
  // Level selection; a sample on the level is replaced in both gated modes
  function integer pick(input integer m, input integer rep, input integer s);
    pick = ((m == 1 && s <= 10) || (m == 2 && s >= 10)) ? rep : s;
  endfunction

  // Sink stalls so the two-entry buffer fills and pushes back on the source
  task stall;
    begin
      sum_ready = 1'b0;
      repeat (12) @(negedge clock);
      check(sample_ready, 1'b0);
      sum_ready = 1'b1;
    end
  endtask

  task run_case(input integer c);
    integer seg, pos, a, n;
    integer s0 [0:2];
    integer s1 [0:2];
    begin
      a = (avg_t[c] < 2) ? 2 : avg_t[c];
      wr_rd(`BAVG_OFS_MODE_CH0, m0_t[c], m0_t[c]);
      wr_rd(`BAVG_OFS_MODE_CH1, m1_t[c], m1_t[c]);
      wr_rd(`BAVG_OFS_CH_ENABLE, en_t[c], en_t[c]);
      wr_rd(`BAVG_OFS_AVG_COUNT, avg_t[c], a);
      for (pos = 0; pos < 3; pos++) begin
        s0[pos] = 0;
        s1[pos] = 0;
      end
      if (c == 0) fork
        stall;
      join_none
      for (seg = 0; seg < a; seg++) begin
        for (pos = 0; pos < 3; pos++) begin
          s0[pos] = s0[pos] + pick(m0_t[c], -5, raw(seg, pos));
          s1[pos] = s1[pos] + pick(m1_t[c], 20, -raw(seg, pos));
          u_adc.send(16'(raw(seg, pos)), 16'(-raw(seg, pos)));
        end
        // Source released while the live position is read back
        if (seg == 0) begin
          u_adc.idle;
          reg_read(`BAVG_OFS_STATUS, v);
          check(v, 32'h1);
        end
      end
      u_adc.idle;
      for (pos = 0; pos < 3; pos++) begin
        if (en_t[c] % 2 == 1) exp_q.push_back({1'b0, 32'(s0[pos])});
        if (en_t[c] > 1) exp_q.push_back({1'b1, 32'(s1[pos])});
      end
      n = 0;
      while (got.size() < exp_q.size() && n < 500) begin
        @(negedge clock);
        n++;
      end
      check(33'(got.size()), 33'(exp_q.size()));
      while (exp_q.size() > 0) check(got.pop_front(), exp_q.pop_front());
    end
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0;
    sum_ready = 1'b1;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    reg_read(`BAVG_OFS_AVG_COUNT, v);
    check(v, 32'h2);
    reg_read(`BAVG_OFS_SEG_SIZE, v);
    check(v, 32'h400);
    reg_read(`BAVG_OFS_THR_CH1, v);
    check(v, 32'h0);
    reg_read(16'h1234, v);
    check(v, 32'h0);
    wr_rd(`BAVG_OFS_THR_CH0, 32'd5000, 32'h7ff);
    wr_rd(`BAVG_OFS_REPL_CH1, -32'sd5000, 32'hfffff801);
    wr_rd(`BAVG_OFS_THR_CH0, 32'd10, 32'd10);
    wr_rd(`BAVG_OFS_THR_CH1, 32'd10, 32'd10);
    wr_rd(`BAVG_OFS_REPL_CH0, -32'sd5, 32'hfffffffb);
    wr_rd(`BAVG_OFS_REPL_CH1, 32'd20, 32'd20);
    wr_rd(`BAVG_OFS_SEG_SIZE, 32'd3, 32'd3);
    for (k = 0; k < 3; k++) run_case(k);
    results;
  end

  // Watchdog, far beyond the few hundred cycles the cases need
  initial begin
    #200000;
    err_total = err_total + 1;
    results;
  end
endmodule
`default_nettype wire
